// ---- common/ua_pkg.sv ----
// shared constants, types and helpers for the enhanced uart and its controller
package ua_pkg;
   // register offsets on the device's special register port
   localparam logic [7:0] UA_OFS_POWER_AND_BAUD_CONTROL = 8'h87;
   localparam logic [7:0] UA_OFS_SERIAL_CONTROL_STATUS = 8'h98;
   localparam logic [7:0] UA_OFS_SERIAL_DATA_BUFFER = 8'h99;
   localparam logic [7:0] UA_OFS_SLAVE_ADDRESS_VALUE = 8'h9a;
   localparam logic [7:0] UA_OFS_SLAVE_ADDRESS_MASK = 8'h9b;
   localparam logic [7:0] UA_RST_REG = 8'h00;
   // power_control fields
   localparam int UA_PC_DOUBLER = 7;
   localparam int UA_PC_VIEW = 6;
   localparam logic [7:0] UA_PC_WR_MASK = 8'hcf;
   // serial_control fields
   localparam int UA_SC_TOP_LSB = 5;
   localparam int UA_SC_FE = 7;
   localparam int UA_SC_OVR = 6;
   localparam int UA_SC_COL = 5;
   localparam int UA_SC_REN = 4;
   localparam int UA_SC_TB8 = 3;
   localparam int UA_SC_RB8 = 2;
   localparam int UA_SC_TI = 1;
   localparam int UA_SC_RI = 0;
   // operating modes, {mode_select_high, mode_select_low}
   typedef enum logic [1:0] {
      UA_MODE_SYNC = 2'b00,
      UA_MODE_VAR8 = 2'b01,
      UA_MODE_FIX9 = 2'b10,
      UA_MODE_VAR9 = 2'b11
   } ua_mode_t;
   // timing counts in clocks or sample ticks
   localparam logic [3:0] UA_HALF_SYNC_SLOW = 4'h5;
   localparam logic [3:0] UA_HALF_SYNC_FAST = 4'h1;
   localparam logic [3:0] UA_DIV_FIX = 4'h3;
   localparam logic [3:0] UA_DIV_FIX_DBL = 4'h1;
   localparam logic [3:0] UA_TICK_LAST = 4'hf;
   localparam logic [3:0] UA_SAMPLE_A = 4'h7;
   localparam logic [3:0] UA_SAMPLE_B = 4'h8;
   localparam logic [3:0] UA_SAMPLE_C = 4'h9;
   localparam logic [3:0] UA_STOP_IDX8 = 4'h9;
   localparam logic [3:0] UA_STOP_IDX9 = 4'ha;
   localparam logic [3:0] UA_NINTH_IDX = 4'h9;
   localparam logic [3:0] UA_SYNC_LAST_BIT = 4'h7;
   localparam logic [3:0] UA_BREAK_BITS = 4'hb;
   // axi4-lite side
   localparam int UA_AXI_AW = 10;
   localparam logic [1:0] UA_RESP_OKAY = 2'h0;
   localparam logic [1:0] UA_RESP_SLVERR = 2'h2;

   // given address (masked) or broadcast address (value or mask)
   function automatic logic ua_addr_match(input logic [7:0] rx, input logic [7:0] val,
                                          input logic [7:0] msk);
      logic given;
      logic bcast;
      given = ((rx ^ val) & msk) == 8'h00;
      bcast = (rx | ~(val | msk)) == 8'hff;
      return given | bcast;
   endfunction : ua_addr_match

   function automatic logic ua_sfr_known(input logic [7:0] a);
      return (a == UA_OFS_POWER_AND_BAUD_CONTROL) || (a == UA_OFS_SERIAL_CONTROL_STATUS)
         || (a == UA_OFS_SERIAL_DATA_BUFFER) || (a == UA_OFS_SLAVE_ADDRESS_VALUE)
         || (a == UA_OFS_SLAVE_ADDRESS_MASK);
   endfunction : ua_sfr_known
endpackage : ua_pkg

// ---- common/ua_sfr_if.sv ----
// special register port joining the uart and its bus controller
`timescale 1ns/1ps
interface ua_sfr_if;
   logic [7:0] sfr_addr;
   logic sfr_wr;
   logic sfr_rd;
   logic [7:0] sfr_wdata;
   logic [7:0] sfr_rdata;
   modport dev (input sfr_addr, input sfr_wr, input sfr_rd, input sfr_wdata, output sfr_rdata);
   modport host (output sfr_addr, output sfr_wr, output sfr_rd, output sfr_wdata,
                 input sfr_rdata);
endinterface : ua_sfr_if

// ---- rtl/ua_euart_dev.sv ----
// enhanced uart: registers, shifters, address recognition and line errors
`timescale 1ns/1ps
module ua_euart_dev (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic rxd_in,
   output logic rxd_out,
   output logic rxd_oe,
   output logic txd,
   input wire logic baud_ovf,
   input wire logic t2_sel,
   output logic line_break,
   ua_sfr_if.dev sfr
);
   import ua_pkg::*;

   typedef enum logic [2:0] {
      RX_IDLE = 3'b001,
      RX_BITS = 3'b010,
      RX_HOLD = 3'b100
   } ua_rx_state_t;

   logic [2:0] ctl_top;
   logic framing_error_flag, overrun_flag, tx_collision_flag;
   logic rx_enable, tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_done_flag, rx_unread;
   logic [7:0] power_control, slave_address_value, slave_address_mask, rx_latch;
   logic [3:0] div_cnt;
   logic ovf_tog;
   logic tx_busy, m0_rx, ti_set, m0_done, m0_phase;
   logic [9:0] tx_sh;
   logic [7:0] m0_sh;
   logic [3:0] tx_cnt, tx_bitn;
   ua_rx_state_t rx_state;
   logic rx_s1, rx_s, rx_prev;
   logic [1:0] vote;
   logic [3:0] rx_cnt, rx_bitn, low_run;
   logic [7:0] rx_sh, ld_data;
   logic rx_b9, ld_pulse, ld_b8, fe_set;

   // mode and control decode
   wire ua_mode_t mode = ua_mode_t'(ctl_top[2:1]);
   wire multiproc_enable = ctl_top[0];
   wire nine = mode[1];
   wire baud_doubler = power_control[UA_PC_DOUBLER];
   wire status_view_select = power_control[UA_PC_VIEW];
   wire wr_power_and_baud_control = sfr.sfr_wr && sfr.sfr_addr == UA_OFS_POWER_AND_BAUD_CONTROL;
   wire wr_serial_control = sfr.sfr_wr && sfr.sfr_addr == UA_OFS_SERIAL_CONTROL_STATUS;
   wire wr_serial_buffer = sfr.sfr_wr && sfr.sfr_addr == UA_OFS_SERIAL_DATA_BUFFER;
   wire wr_slave_address_value = sfr.sfr_wr && sfr.sfr_addr == UA_OFS_SLAVE_ADDRESS_VALUE;
   wire wr_smask = sfr.sfr_wr && sfr.sfr_addr == UA_OFS_SLAVE_ADDRESS_MASK;
   wire rd_serial_buffer = sfr.sfr_rd && sfr.sfr_addr == UA_OFS_SERIAL_DATA_BUFFER;
   wire [7:0] wd = sfr.sfr_wdata;

   // rate generation: sync half periods, fixed 16x ticks, or timer overflows
   wire [3:0] sync_half = multiproc_enable ? UA_HALF_SYNC_FAST : UA_HALF_SYNC_SLOW;
   wire [3:0] fix_div = baud_doubler ? UA_DIV_FIX_DBL : UA_DIV_FIX;
   wire [3:0] div_last = (mode == UA_MODE_SYNC) ? sync_half : fix_div;
   wire div_hit = div_cnt == div_last;
   wire ovf_halve = t2_sel || !baud_doubler;
   wire var_tick = baud_ovf && (!ovf_halve || ovf_tog);
   wire var_mode = mode == UA_MODE_VAR8 || mode == UA_MODE_VAR9;
   wire tick16 = (mode == UA_MODE_FIX9) ? div_hit : (var_mode && var_tick);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_cnt <= 4'h0;
         ovf_tog <= 1'b0;
      end else begin
         div_cnt <= div_hit ? 4'h0 : 4'(div_cnt + 4'h1);
         ovf_tog <= ovf_tog ^ baud_ovf;
      end
   end

   // transmit side, also runs the sync-mode shift clock for both directions
   wire [3:0] stop_idx = nine ? UA_STOP_IDX9 : UA_STOP_IDX8;
   wire sync_mode = mode == UA_MODE_SYNC;
   wire tx_start = wr_serial_buffer && !tx_busy && !m0_rx;
   wire col_set = wr_serial_buffer && (tx_busy || m0_rx);
   wire m0_rx_go = sync_mode && rx_enable && !rx_done_flag && !tx_busy && !m0_rx
      && !wr_serial_buffer;
   wire [3:0] tx_next = 4'(tx_bitn + 4'h1);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_busy <= 1'b0;
         m0_rx <= 1'b0;
         m0_phase <= 1'b0;
         tx_sh <= 10'h3ff;
         m0_sh <= 8'h00;
         tx_cnt <= 4'h0;
         tx_bitn <= 4'h0;
         txd <= 1'b1;
         rxd_out <= 1'b1;
         rxd_oe <= 1'b0;
         ti_set <= 1'b0;
         m0_done <= 1'b0;
      end else begin
         ti_set <= 1'b0;
         m0_done <= 1'b0;
         if (tx_start) begin
            tx_busy <= 1'b1;
            tx_cnt <= 4'h0;
            tx_bitn <= 4'h0;
            m0_phase <= 1'b0;
            if (sync_mode) begin
               tx_sh <= {2'h3, wd};
               rxd_out <= wd[0];
               rxd_oe <= 1'b1;
            end else begin
               tx_sh <= {1'b1, nine ? tx_ninth_bit : 1'b1, wd};
               txd <= 1'b0;
            end
         end else if (m0_rx_go) begin
            m0_rx <= 1'b1;
            tx_bitn <= 4'h0;
            m0_phase <= 1'b0;
         end else if ((tx_busy || m0_rx) && sync_mode && div_hit) begin
            // low half, rising edge (partner samples), then end of bit time
            if (!txd) begin
               txd <= 1'b1;
               m0_phase <= 1'b1;
               if (m0_rx) m0_sh <= {rx_s, m0_sh[7:1]};
            end else if (!m0_phase) begin
               txd <= 1'b0;
            end else if (tx_bitn == UA_SYNC_LAST_BIT) begin
               tx_busy <= 1'b0;
               m0_rx <= 1'b0;
               rxd_oe <= 1'b0;
               ti_set <= tx_busy;
               m0_done <= m0_rx;
            end else begin
               m0_phase <= 1'b0;
               tx_bitn <= tx_next;
               tx_sh <= {1'b1, tx_sh[9:1]};
               rxd_out <= tx_sh[1];
               txd <= 1'b0;
            end
         end else if (tx_busy && !sync_mode && tick16) begin
            tx_cnt <= 4'(tx_cnt + 4'h1);
            if (tx_cnt == UA_TICK_LAST) begin
               if (tx_bitn == stop_idx) begin
                  tx_busy <= 1'b0;
               end else begin
                  tx_bitn <= tx_next;
                  txd <= tx_sh[0];
                  tx_sh <= {1'b1, tx_sh[9:1]};
                  if (tx_next == stop_idx) ti_set <= 1'b1;
               end
            end
         end
      end
   end

   // receive side: 16x sampling with 2-of-3 vote at samples 7, 8, 9
   wire rx_fall = rx_prev && !rx_s;
   wire maj = (vote[0] & vote[1]) | (rx_s & (vote[0] | vote[1]));
   wire addr_hit = ua_addr_match(rx_sh, slave_address_value,
      slave_address_mask);
   wire ok9 = !multiproc_enable || (rx_b9 && addr_hit);
   wire ok8 = !multiproc_enable || maj;
   wire accept = !rx_done_flag && (nine ? ok9 : ok8);
   wire [3:0] low_inc = (low_run == UA_TICK_LAST) ? low_run : 4'(low_run + 4'h1);
   wire brk_now = low_inc >= UA_BREAK_BITS;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_s1 <= 1'b1;
         rx_s <= 1'b1;
         rx_prev <= 1'b1;
         rx_state <= RX_IDLE;
         vote <= 2'h3;
         rx_cnt <= 4'h0;
         rx_bitn <= 4'h0;
         low_run <= 4'h0;
         rx_sh <= 8'h00;
         rx_b9 <= 1'b0;
         ld_pulse <= 1'b0;
         ld_data <= 8'h00;
         ld_b8 <= 1'b0;
         fe_set <= 1'b0;
         line_break <= 1'b0;
      end else begin
         rx_s1 <= rxd_in;
         rx_s <= rx_s1;
         rx_prev <= rx_s;
         ld_pulse <= m0_done;
         fe_set <= 1'b0;
         if (m0_done) begin
            ld_data <= m0_sh;
            ld_b8 <= rx_ninth_bit; // unused in sync mode, left as is
         end
         case (rx_state)
            RX_IDLE: begin
               if (rx_enable && rx_fall && !sync_mode) begin
                  rx_state <= RX_BITS;
                  rx_cnt <= 4'h0;
                  rx_bitn <= 4'h0;
               end
            end
            RX_BITS: begin
               if (!rx_enable || sync_mode) begin
                  rx_state <= RX_IDLE;
               end else if (tick16) begin
                  rx_cnt <= 4'(rx_cnt + 4'h1);
                  if (rx_cnt == UA_SAMPLE_A) vote[0] <= rx_s;
                  if (rx_cnt == UA_SAMPLE_B) vote[1] <= rx_s;
                  if (rx_cnt == UA_SAMPLE_C) begin
                     low_run <= maj ? 4'h0 : low_inc;
                     if (rx_bitn == 4'h0 && maj) begin
                        rx_state <= RX_IDLE; // false start
                     end else if (rx_bitn == stop_idx) begin
                        rx_state <= maj ? RX_IDLE : RX_HOLD;
                        fe_set <= !maj;
                        line_break <= !maj && brk_now;
                        if (accept) begin
                           ld_pulse <= 1'b1;
                           ld_data <= rx_sh;
                           ld_b8 <= nine ? rx_b9 : maj;
                        end
                     end else begin
                        rx_bitn <= 4'(rx_bitn + 4'h1);
                        if (rx_bitn == UA_NINTH_IDX) rx_b9 <= maj;
                        else if (rx_bitn != 4'h0) rx_sh <= {maj, rx_sh[7:1]};
                     end
                  end
               end
            end
            RX_HOLD: begin
               // line still low: keep counting bit times toward a break
               if (rx_s) begin
                  rx_state <= RX_IDLE;
                  line_break <= 1'b0;
                  low_run <= 4'h0;
               end else if (tick16) begin
                  rx_cnt <= 4'(rx_cnt + 4'h1);
                  if (rx_cnt == UA_SAMPLE_C) begin
                     low_run <= low_inc;
                     if (brk_now) begin
                        line_break <= 1'b1;
                        fe_set <= 1'b1;
                     end
                  end
               end
            end
            default: rx_state <= RX_IDLE;
         endcase
      end
   end

   // register file; hardware sets win over a software clear in the same cycle
   wire clr_ok = wr_serial_control && status_view_select;
   wire [2:0] top_rd = status_view_select
      ? {framing_error_flag, overrun_flag, tx_collision_flag} : ctl_top;
   wire [7:0] serial_control_rd = {top_rd, rx_enable, tx_ninth_bit, rx_ninth_bit, tx_done_flag,
      rx_done_flag};
   wire [7:0] rd_mux = (sfr.sfr_addr == UA_OFS_POWER_AND_BAUD_CONTROL) ? power_control
      : (sfr.sfr_addr == UA_OFS_SERIAL_CONTROL_STATUS) ? serial_control_rd
      : (sfr.sfr_addr == UA_OFS_SERIAL_DATA_BUFFER) ? rx_latch
      : (sfr.sfr_addr == UA_OFS_SLAVE_ADDRESS_VALUE) ? slave_address_value
      : (sfr.sfr_addr == UA_OFS_SLAVE_ADDRESS_MASK) ? slave_address_mask : 8'h00;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         power_control <= UA_RST_REG;
         ctl_top <= 3'h0;
         {rx_enable, tx_ninth_bit, rx_ninth_bit} <= 3'h0;
         slave_address_value <= UA_RST_REG;
         slave_address_mask <= UA_RST_REG;
         {framing_error_flag, overrun_flag, tx_collision_flag} <= 3'h0;
         {tx_done_flag, rx_done_flag, rx_unread} <= 3'h0;
         rx_latch <= UA_RST_REG;
         sfr.sfr_rdata <= UA_RST_REG;
      end else begin
         if (wr_power_and_baud_control) power_control <= wd & UA_PC_WR_MASK;
         if (wr_slave_address_value) slave_address_value <= wd;
         if (wr_smask) slave_address_mask <= wd;
         if (wr_serial_control) begin
            if (!status_view_select) ctl_top <= wd[7:UA_SC_TOP_LSB];
            rx_enable <= wd[UA_SC_REN];
            tx_ninth_bit <= wd[UA_SC_TB8];
         end
         if (ld_pulse) rx_ninth_bit <= ld_b8;
         else if (wr_serial_control) rx_ninth_bit <= wd[UA_SC_RB8];
         if (ld_pulse) rx_latch <= ld_data;
         framing_error_flag <= (framing_error_flag & ~(clr_ok & ~wd[UA_SC_FE]))
            | fe_set;
         overrun_flag <= (overrun_flag & ~(clr_ok & ~wd[UA_SC_OVR]))
            | (ld_pulse & rx_unread);
         tx_collision_flag <= (tx_collision_flag & ~(clr_ok & ~wd[UA_SC_COL]))
            | col_set;
         tx_done_flag <= (wr_serial_control ? wd[UA_SC_TI] : tx_done_flag) | ti_set;
         rx_done_flag <= (wr_serial_control ? wd[UA_SC_RI] : rx_done_flag) | ld_pulse;
         rx_unread <= (rx_unread & ~rd_serial_buffer) | ld_pulse;
         if (sfr.sfr_rd) sfr.sfr_rdata <= rd_mux;
      end
   end
endmodule : ua_euart_dev

// ---- rtl/ua_sfr_ctrl.sv ----
// axi4-lite slave that turns bus words into special register accesses
`timescale 1ns/1ps
module ua_sfr_ctrl (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ua_pkg::UA_AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ua_pkg::UA_AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   ua_sfr_if.host sfr
);
   import ua_pkg::*;

   typedef enum logic [6:0] {
      ST_IDLE = 7'b0000001,
      ST_AR = 7'b0000010,
      ST_RWAIT = 7'b0000100,
      ST_RCAP = 7'b0001000,
      ST_RRESP = 7'b0010000,
      ST_W = 7'b0100000,
      ST_BRESP = 7'b1000000
   } ua_ctl_state_t;

   ua_ctl_state_t state;
   logic got_aw, got_w, wr_en, rd_known;

   // word index on the bus is the register offset; only byte lane 0 is used
   wire aw_hs = s_axi_awvalid && s_axi_awready;
   wire w_hs = s_axi_wvalid && s_axi_wready;
   wire ar_hs = s_axi_arvalid && s_axi_arready;
   wire [7:0] cur_idx = aw_hs ? s_axi_awaddr[9:2] : sfr.sfr_addr;
   wire [7:0] cur_data = w_hs ? s_axi_wdata[7:0] : sfr.sfr_wdata;
   wire cur_en = w_hs ? s_axi_wstrb[0] : wr_en;
   wire cur_known = ua_sfr_known(cur_idx);
   wire [7:0] ar_idx = s_axi_araddr[9:2];
   wire ar_known = ua_sfr_known(ar_idx);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= ST_IDLE;
         {s_axi_awready, s_axi_wready, s_axi_arready} <= 3'h0;
         {s_axi_bvalid, s_axi_rvalid} <= 2'h0;
         s_axi_bresp <= UA_RESP_OKAY;
         s_axi_rresp <= UA_RESP_OKAY;
         s_axi_rdata <= 32'h0;
         {got_aw, got_w, wr_en, rd_known} <= 4'h0;
         sfr.sfr_addr <= 8'h00;
         sfr.sfr_wdata <= 8'h00;
         sfr.sfr_wr <= 1'b0;
         sfr.sfr_rd <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               // reads first; one transfer in flight at a time
               if (s_axi_arvalid) begin
                  s_axi_arready <= 1'b1;
                  state <= ST_AR;
               end else if (s_axi_awvalid || s_axi_wvalid) begin
                  s_axi_awready <= 1'b1;
                  s_axi_wready <= 1'b1;
                  state <= ST_W;
               end
            end
            ST_AR: begin
               if (ar_hs) begin
                  s_axi_arready <= 1'b0;
                  sfr.sfr_addr <= ar_idx;
                  sfr.sfr_rd <= ar_known;
                  rd_known <= ar_known;
                  state <= ST_RWAIT;
               end
            end
            ST_RWAIT: begin
               sfr.sfr_rd <= 1'b0;
               state <= ST_RCAP;
            end
            ST_RCAP: begin
               s_axi_rdata <= rd_known ? {24'h0, sfr.sfr_rdata} : 32'h0;
               s_axi_rresp <= rd_known ? UA_RESP_OKAY : UA_RESP_SLVERR;
               s_axi_rvalid <= 1'b1;
               state <= ST_RRESP;
            end
            ST_RRESP: begin
               if (s_axi_rready) begin
                  s_axi_rvalid <= 1'b0;
                  state <= ST_IDLE;
               end
            end
            ST_W: begin
               // address and data may be taken in either order
               if (aw_hs) begin
                  s_axi_awready <= 1'b0;
                  got_aw <= 1'b1;
                  sfr.sfr_addr <= cur_idx;
               end
               if (w_hs) begin
                  s_axi_wready <= 1'b0;
                  got_w <= 1'b1;
                  wr_en <= cur_en;
                  sfr.sfr_wdata <= cur_data;
               end
               if ((got_aw || aw_hs) && (got_w || w_hs)) begin
                  sfr.sfr_wr <= cur_en && cur_known;
                  s_axi_bresp <= cur_known ? UA_RESP_OKAY : UA_RESP_SLVERR;
                  s_axi_bvalid <= 1'b1;
                  got_aw <= 1'b0;
                  got_w <= 1'b0;
                  state <= ST_BRESP;
               end
            end
            ST_BRESP: begin
               sfr.sfr_wr <= 1'b0;
               if (s_axi_bready) begin
                  s_axi_bvalid <= 1'b0;
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
endmodule : ua_sfr_ctrl

// ---- sim/ua_link_assertions.sv ----
// concurrent checks on the register port, the receive pin and the break flag
`timescale 1ns/1ps
module ua_link_assertions (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_rdata,
   input wire logic rxd_in,
   input wire logic line_break
);
   import ua_pkg::*;
   logic [9:0] low_cnt;
   // raw low run of the pin; saturates so a long break cannot wrap it
   always_ff @(posedge aclk) begin
      if (!aresetn || rxd_in) low_cnt <= 10'h000;
      else if (low_cnt < 10'h3ff) low_cnt <= low_cnt + 10'h001;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_wr_one_pulse: assert property (sfr_wr |=> !sfr_wr)
      else $error("write strobe longer than one cycle");
   a_access_gap: assert property ((sfr_wr || sfr_rd) |=> !(sfr_wr || sfr_rd) [*2])
      else $error("register accesses too close");
   a_no_rd_wr: assert property (!(sfr_wr && sfr_rd))
      else $error("read and write together");
   a_known_offset: assert property ((sfr_wr || sfr_rd) |-> ua_sfr_known(sfr_addr))
      else $error("access to an unmapped offset passed on");
   a_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
      else $error("read data moved without a read");
   a_break_len: assert property ($rose(line_break) |-> low_cnt >= 10'h0aa)
      else $error("break flagged before eleven bit times");
   a_break_holds: assert property (line_break && !rxd_in |=> line_break)
      else $error("break left while line still low");
   a_break_ends: assert property (rxd_in [*5] |-> !line_break)
      else $error("break kept after line returned high");
   // main scenarios reached
   cover property (sfr_wr && sfr_addr == UA_OFS_SERIAL_DATA_BUFFER);
   cover property (sfr_rd && sfr_addr == UA_OFS_SLAVE_ADDRESS_MASK);
   cover property ($rose(line_break));
endmodule : ua_link_assertions

// ---- sim/uart_addr_recognition_status_bench.sv ----
// bench joining controller and uart, the uart looped back on itself
`timescale 1ns/1ps
module uart_addr_recognition_status_bench;
   import ua_pkg::*;
   localparam logic [7:0] PC = UA_OFS_POWER_AND_BAUD_CONTROL;
   localparam logic [7:0] SC = UA_OFS_SERIAL_CONTROL_STATUS;
   localparam logic [7:0] DB = UA_OFS_SERIAL_DATA_BUFFER;
   logic aclk = 0, aresetn = 0, loop = 1, rx_b = 1, baud_ovf = 1, t2_sel = 0;
   logic [9:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, txd, line_break;
   logic [1:0] bresp, rresp, resp;
   logic [7:0] v;
   int fails = 0, checked = 0, cycles = 0;
   wire rxd_w = loop ? txd : rx_b; // loopback unless the bench holds the line
   ua_sfr_if sfr ();
   ua_euart_dev i_ua_euart_dev (.aclk(aclk), .aresetn(aresetn), .rxd_in(rxd_w), .rxd_out(),
      .rxd_oe(), .txd(txd), .baud_ovf(baud_ovf), .t2_sel(t2_sel), .line_break(line_break),
      .sfr(sfr.dev));
   ua_sfr_ctrl i_ua_sfr_ctrl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sfr(sfr.host));
   ua_link_assertions i_ua_link_assertions (.aclk(aclk), .aresetn(aresetn),
      .sfr_addr(sfr.sfr_addr), .sfr_wr(sfr.sfr_wr), .sfr_rd(sfr.sfr_rd),
      .sfr_rdata(sfr.sfr_rdata), .rxd_in(rxd_w), .line_break(line_break));
   // 40 MHz clock and a hang guard far above the ~3000 cycles needed
   initial forever #12.5 aclk = ~aclk;
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         stop_test;
      end
   end
   task stop_test;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : stop_test
   task chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // bus cycles: hold each valid until its own ready is seen
   task wr(input logic [7:0] ofs, input logic [7:0] d);
      logic aw_ok, w_ok;
      aw_ok = 0;
      w_ok = 0;
      awaddr <= {ofs, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (awready) aw_ok = 1;
         if (wready) w_ok = 1;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      @(posedge aclk);
      while (!bvalid) @(posedge aclk);
      resp = bresp;
      bready <= 1'b0;
      // let an edge pass so a following call never re-drives bready in this step
      @(posedge aclk);
   endtask : wr
   task rd(input logic [7:0] ofs);
      araddr <= {ofs, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(posedge aclk);
      while (!arready) @(posedge aclk);
      arvalid <= 1'b0;
      @(posedge aclk);
      while (!rvalid) @(posedge aclk);
      v = rdata[7:0];
      resp = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask : rd
   task rc(input logic [7:0] ofs, input logic [7:0] mask, input logic [7:0] exp);
      rd(ofs);
      chk(v & mask, exp);
   endtask : rc
   // one frame is 10 or 11 bits of 16 clocks each (32 clocks in s_rate)
   task send(input logic [7:0] d);
      wr(DB, d);
      repeat (220) @(posedge aclk);
   endtask : send
   task s_reset;
      logic [7:0] ofs [5];
      ofs = '{PC, SC, DB, UA_OFS_SLAVE_ADDRESS_VALUE, UA_OFS_SLAVE_ADDRESS_MASK};
      foreach (ofs[i]) rc(ofs[i], 8'hff, UA_RST_REG);
      rd(8'h10);
      chk({6'h0, resp}, {6'h0, UA_RESP_SLVERR});
      wr(8'h10, 8'h5a);
      chk({6'h0, resp}, {6'h0, UA_RESP_SLVERR});
   endtask : s_reset
   // given address a4/fa, broadcast fe; last case has ninth bit 0
   task s_addr;
      logic [7:0] b [4];
      logic [3:0] hit;
      b = '{8'ha0, 8'ha2, 8'hfe, 8'ha0};
      hit = 4'b0101;
      wr(PC, 8'h80);
      wr(UA_OFS_SLAVE_ADDRESS_VALUE, 8'ha4);
      wr(UA_OFS_SLAVE_ADDRESS_MASK, 8'hfa);
      for (int i = 0; i < 4; i++) begin
         wr(SC, (i == 3) ? 8'hf0 : 8'hf8);
         send(b[i]);
         rc(SC, 8'h01, {7'h0, hit[i]});
         if (hit[i]) rc(DB, 8'hff, b[i]);
      end
   endtask : s_addr
   task s_err;
      wr(SC, 8'h50);
      send(8'h55);
      wr(SC, 8'h50);
      wr(DB, 8'h33);
      wr(DB, 8'h44);
      repeat (220) @(posedge aclk);
      rc(SC, 8'h05, 8'h05);
      rc(DB, 8'hff, 8'h33);
      wr(PC, 8'hc0);
      wr(SC, 8'hf0);
      send(8'h5a);
      rc(SC, 8'he0, 8'h60);
      wr(SC, 8'h10);
      rc(SC, 8'he0, 8'h00);
      wr(PC, 8'h80);
      rc(SC, 8'he0, 8'h40);
   endtask : s_err
   // 32-clock bits: timer 2 halves the overflows, then fixed nine-bit mode
   task s_rate;
      logic [7:0] ctl [2];
      ctl = '{8'h50, 8'h98};
      t2_sel <= 1'b1;
      foreach (ctl[i]) begin
         wr(SC, ctl[i]);
         send(8'h3c);
         rc(SC, 8'h03, 8'h00);
         repeat (200) @(posedge aclk);
         rc(SC, 8'h03, 8'h03);
         rc(DB, 8'hff, 8'h3c);
      end
      t2_sel <= 1'b0;
      wr(SC, 8'h50);
   endtask : s_rate
   task s_brk;
      loop <= 1'b0;
      rx_b <= 1'b0;
      repeat (240) @(posedge aclk);
      chk({7'h0, line_break}, 8'h01);
      wr(PC, 8'hc0);
      rc(SC, 8'h80, 8'h80);
      rx_b <= 1'b1;
      repeat (8) @(posedge aclk);
      chk({7'h0, line_break}, 8'h00);
   endtask : s_brk
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      s_reset;
      s_addr;
      s_err;
      s_rate;
      s_brk;
      stop_test;
   end
endmodule : uart_addr_recognition_status_bench
